// ### shared/pct_pkg.sv
package pct_pkg;
  localparam int TABLE_DEPTH = 4096;
  localparam int WAVE_DEPTH = 16000;
  localparam int PROG_DEPTH = 32768;
  localparam int MIN_WAVE_LEN = 16;
  localparam int SEQ_CYCLE_PS = 4000;
  localparam int MCLK_PERIOD_PS = 20000;
  localparam int SEQ_CYCLES = (SEQ_CYCLE_PS / MCLK_PERIOD_PS) < 1 ? 1 :
    (SEQ_CYCLE_PS / MCLK_PERIOD_PS);
  localparam int CT_IDX_W = 16;
  localparam int WAVE_W = 14;
  localparam int LEN_W = 16;
  localparam int PROG_AW = 15;
  localparam int VAL_W = 16;
  localparam int OSC_W = 2;
  localparam int OSC_COUNT = 1 << OSC_W;
  localparam int ACC_W = 32;
  localparam logic [VAL_W-1:0] GAIN_RESET = 16'h0000;
  localparam logic [VAL_W-1:0] PHASE_RESET = 16'h0000;
  localparam logic [OSC_W-1:0] OSC_RESET = 2'h0;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_RUN = 12'h004;
  localparam logic [11:0] REG_CT_ADDR = 12'h008;
  localparam logic [11:0] REG_CT_DATA0 = 12'h00C;
  localparam logic [11:0] REG_CT_DATA1 = 12'h010;
  localparam logic [11:0] REG_CT_DATA2 = 12'h014;
  localparam logic [11:0] REG_CT_DATA3 = 12'h018;
  localparam logic [11:0] REG_CT_COMMIT = 12'h01C;
  localparam logic [11:0] REG_BIND = 12'h020;
  localparam logic [11:0] REG_SAMPLE_ADDR = 12'h024;
  localparam logic [11:0] REG_SAMPLE_DATA = 12'h028;
  localparam logic [11:0] REG_PROG_ADDR = 12'h02C;
  localparam logic [11:0] REG_PROG_DATA = 12'h030;
  localparam logic [11:0] REG_STATUS = 12'h034;
  localparam int BIND_DUAL_BIT = 14;
  localparam int LEN_POS = 16;

  typedef struct packed {
    logic waveEn;
    logic [WAVE_W-1:0] wave;
    logic phaseEn;
    logic phaseInc;
    logic [VAL_W-1:0] phase;
    logic [3:0] gainEn;
    logic [3:0] gainInc;
    logic [3:0][VAL_W-1:0] gain;
    logic oscEn;
    logic [OSC_W-1:0] osc;
  } ct_entry_t;

  localparam int CT_ENTRY_W = $bits(ct_entry_t);
endpackage : pct_pkg

// ### shared/pct_if.sv
`timescale 1ns/1ps
interface pct_if;
  logic runValid;
  logic [pct_pkg::CT_IDX_W-1:0] runIndex;
  logic ctWe;
  logic [pct_pkg::CT_IDX_W-1:0] ctAddr;
  pct_pkg::ct_entry_t ctData;
  logic bindWe;
  logic [pct_pkg::WAVE_W-1:0] bindWave;
  logic [pct_pkg::LEN_W-1:0] bindLen;
  logic bindDual;
  logic sampleWe;
  logic [pct_pkg::WAVE_W-1:0] sampleWave;
  logic [pct_pkg::LEN_W-1:0] sampleAddr;
  logic [pct_pkg::VAL_W-1:0] sampleData;
  logic progLoad;
  logic progWe;
  logic [pct_pkg::PROG_AW-1:0] progAddr;
  logic [31:0] progData;
  logic [pct_pkg::PROG_AW-1:0] fetchAddr;
  logic [31:0] fetchData;
  logic playStart;
  logic runError;
  logic bindError;

  modport dev (
    input runValid, runIndex, ctWe, ctAddr, ctData, bindWe, bindWave,
    bindLen, bindDual, sampleWe, sampleWave, sampleAddr, sampleData,
    progLoad, progWe, progAddr, progData, fetchAddr,
    output fetchData, playStart, runError, bindError
  );
  modport seq (
    output runValid, runIndex, ctWe, ctAddr, ctData, bindWe, bindWave,
    bindLen, bindDual, sampleWe, sampleWave, sampleAddr, sampleData,
    progLoad, progWe, progAddr, progData, fetchAddr,
    input fetchData, playStart, runError, bindError
  );
endinterface : pct_if

// ### design/pulse_command_table_engine.sv
// Behaviour
// - entry applies wave, phase, gain in one cycle
// - table storage separate from program and waves
// - phase and gain absolute or incremental
// - entry selects oscillator, phase stays continuous
// - table playback start takes exactly one cycle
// - run call carries only a table index
// - instruction store holds 32768 words
// - wave table holds 16000 bound slots
// - wave index addresses both entries and samples
// - table holds 4096 full entries
// - host loads whole table before use; runs are accepted after any commit with bit 0 set
// - played waves are at least 16 samples
// - sample LSB carries the marker
// - single wave amplitude only, dual gives IQ
// - undefined entry or wave is refused
// - applied settings persist, override host settings
// - program load clears the table
// - increment flag adds signed value to held
`timescale 1ns/1ps
module pulse_command_table_engine (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // sequencer link
  pct_if.dev link,
  // host-set gain, phase and oscillator frequencies
  input wire logic [3:0][pct_pkg::VAL_W-1:0] hostGain,
  input wire logic [pct_pkg::VAL_W-1:0] hostPhase,
  input wire logic [pct_pkg::OSC_COUNT-1:0][pct_pkg::ACC_W-1:0] oscFreq,
  // playback
  output logic playStart,
  output logic [pct_pkg::WAVE_W-1:0] direct_wave_play,
  output logic [pct_pkg::LEN_W-1:0] playLen,
  output logic iqMode,
  output logic [3:0][pct_pkg::VAL_W-1:0] gainOut,
  output logic [pct_pkg::VAL_W-1:0] phaseOut,
  output logic [pct_pkg::OSC_W-1:0] oscSel,
  // waveform memory write
  output logic sampleWe,
  output logic [pct_pkg::WAVE_W-1:0] sampleWave,
  output logic [pct_pkg::LEN_W-1:0] sampleAddr,
  output logic [pct_pkg::VAL_W-1:0] sampleData,
  output logic sampleMarker
);
  localparam int CT_AW = $clog2(pct_pkg::TABLE_DEPTH);
  localparam int WV_AW = $clog2(pct_pkg::WAVE_DEPTH);

  typedef struct packed {
    logic [3:0][pct_pkg::VAL_W-1:0] gain;
    logic [3:0] gainOwn;
    logic [pct_pkg::VAL_W-1:0] phase;
    logic phaseOwn;
    logic [pct_pkg::OSC_W-1:0] osc;
    logic [pct_pkg::OSC_COUNT-1:0][pct_pkg::ACC_W-1:0] acc;
    logic playStart;
    logic [pct_pkg::WAVE_W-1:0] direct_wave_play;
    logic [pct_pkg::LEN_W-1:0] playLen;
    logic iqMode;
    logic [3:0][pct_pkg::VAL_W-1:0] gainOut;
    logic [pct_pkg::VAL_W-1:0] phaseOut;
    logic runError;
    logic bindError;
    logic sampleWe;
    logic [pct_pkg::WAVE_W-1:0] sampleWave;
    logic [pct_pkg::LEN_W-1:0] sampleAddr;
    logic [pct_pkg::VAL_W-1:0] sampleData;
    logic [31:0] fetchData;
  } engine_t;

  engine_t s;
  engine_t next_s;

  // separate stores: table, wave slots, program
  pct_pkg::ct_entry_t ctMem [pct_pkg::TABLE_DEPTH];
  logic [pct_pkg::TABLE_DEPTH-1:0] ctValid;
  logic [pct_pkg::LEN_W-1:0] waveLen [pct_pkg::WAVE_DEPTH];
  logic [pct_pkg::WAVE_DEPTH-1:0] waveDual;
  logic [pct_pkg::WAVE_DEPTH-1:0] waveValid;
  logic [31:0] progMem [pct_pkg::PROG_DEPTH];

  logic ctAddrOk;
  logic bindOk;
  logic runIdxOk;
  logic waveIdxOk;
  logic hit;
  logic [CT_AW-1:0] runSlot;
  logic [WV_AW-1:0] waveSlot;
  pct_pkg::ct_entry_t ent;

  assign ctAddrOk = link.ctAddr < pct_pkg::TABLE_DEPTH;
  assign bindOk = link.bindWe
    && link.bindWave < pct_pkg::WAVE_DEPTH
    && link.bindLen >= pct_pkg::MIN_WAVE_LEN;
  assign runIdxOk = link.runIndex < pct_pkg::TABLE_DEPTH;
  assign runSlot = link.runIndex[CT_AW-1:0];
  assign ent = ctMem[runSlot];
  assign waveIdxOk = ent.wave < pct_pkg::WAVE_DEPTH;
  assign waveSlot = ent.wave[WV_AW-1:0];
  // entry must be loaded and, if it plays a wave, its wave bound
  assign hit = runIdxOk && ctValid[runSlot]
    && (!ent.waveEn || (waveIdxOk && waveValid[waveSlot]));

  always_ff @(posedge mclk)
  begin
    if (reset || link.progLoad)
    begin
      ctValid <= '0;
      waveValid <= '0;
    end
    else
    begin
      if (link.ctWe && ctAddrOk)
      begin
        ctMem[link.ctAddr[CT_AW-1:0]] <= link.ctData;
        ctValid[link.ctAddr[CT_AW-1:0]] <= 1'b1;
      end
      if (bindOk)
      begin
        waveLen[link.bindWave[WV_AW-1:0]] <= link.bindLen;
        waveDual[link.bindWave[WV_AW-1:0]] <= link.bindDual;
        waveValid[link.bindWave[WV_AW-1:0]] <= 1'b1;
      end
    end
    if (link.progWe)
    begin
      progMem[link.progAddr] <= link.progData;
    end
  end

  always_comb
  begin
    next_s = s;
    next_s.playStart = 1'b0;
    next_s.runError = 1'b0;
    next_s.bindError = link.bindWe && !bindOk;
    next_s.fetchData = progMem[link.fetchAddr];
    next_s.sampleWe = link.sampleWe;
    next_s.sampleWave = link.sampleWave;
    next_s.sampleAddr = link.sampleAddr;
    next_s.sampleData = link.sampleData;
    // free-running oscillators, never reset on a switch
    for (int k = 0; k < pct_pkg::OSC_COUNT; k++)
    begin
      next_s.acc[k] = s.acc[k] + oscFreq[k];
    end
    if (link.runValid)
    begin
      if (!hit)
      begin
        next_s.runError = 1'b1;
      end
      else
      begin
        for (int i = 0; i < 4; i++)
        begin
          if (ent.gainEn[i])
          begin
            next_s.gainOwn[i] = 1'b1;
            next_s.gain[i] = ent.gainInc[i] ? s.gain[i] + ent.gain[i]
              : ent.gain[i];
          end
        end
        if (ent.phaseEn)
        begin
          next_s.phaseOwn = 1'b1;
          next_s.phase = ent.phaseInc ? s.phase + ent.phase
            : ent.phase;
        end
        if (ent.oscEn)
        begin
          next_s.osc = ent.osc;
        end
        if (ent.waveEn)
        begin
          next_s.playStart = 1'b1;
          next_s.direct_wave_play = ent.wave;
          next_s.playLen = waveLen[waveSlot];
          next_s.iqMode = waveDual[waveSlot];
        end
      end
    end
    for (int i = 0; i < 4; i++)
    begin
      next_s.gainOut[i] = next_s.gainOwn[i] ? next_s.gain[i]
        : hostGain[i];
    end
    next_s.phaseOut = s.acc[next_s.osc][pct_pkg::ACC_W-1 -: pct_pkg::VAL_W]
      + (next_s.phaseOwn ? next_s.phase : hostPhase);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s <= '0;
      s.gain <= {4{pct_pkg::GAIN_RESET}};
      s.phase <= pct_pkg::PHASE_RESET;
      s.osc <= pct_pkg::OSC_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign playStart = s.playStart;
  assign direct_wave_play = s.direct_wave_play;
  assign playLen = s.playLen;
  assign iqMode = s.iqMode;
  assign gainOut = s.gainOut;
  assign phaseOut = s.phaseOut;
  assign oscSel = s.osc;
  assign sampleWe = s.sampleWe;
  assign sampleWave = s.sampleWave;
  assign sampleAddr = s.sampleAddr;
  assign sampleData = s.sampleData;
  assign sampleMarker = s.sampleData[0];
  assign link.playStart = s.playStart;
  assign link.runError = s.runError;
  assign link.bindError = s.bindError;
  assign link.fetchData = s.fetchData;
endmodule : pulse_command_table_engine

// ### design/table_call_sequencer.sv
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
module table_call_sequencer (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // engine link
  pct_if.seq link
);
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic runValid;
    logic [pct_pkg::CT_IDX_W-1:0] runIndex;
    logic ctWe;
    logic [pct_pkg::CT_IDX_W-1:0] ctAddr;
    logic [3:0][31:0] ctWord;
    logic bindWe;
    logic [pct_pkg::WAVE_W-1:0] bindWave;
    logic [pct_pkg::LEN_W-1:0] bindLen;
    logic bindDual;
    logic sampleWe;
    logic [pct_pkg::WAVE_W-1:0] sampleWave;
    logic [pct_pkg::LEN_W-1:0] sampleAddr;
    logic [pct_pkg::VAL_W-1:0] sampleData;
    logic progLoad;
    logic progWe;
    logic [pct_pkg::PROG_AW-1:0] progAddr;
    logic [31:0] progData;
    logic runErr;
    logic bindErr;
    logic tableLoaded;
    logic [15:0] playCount;
  } seq_t;

  seq_t h;
  seq_t next_h;
  logic mapped;
  logic wr;

  assign mapped = paddr[1:0] == 2'h0 && paddr <= pct_pkg::REG_STATUS;
  assign wr = psel && penable && h.pready && pwrite && mapped;

  always_comb
  begin
    next_h = h;
    next_h.pready = 1'b0;
    next_h.pslverr = 1'b0;
    next_h.runValid = 1'b0;
    next_h.ctWe = 1'b0;
    next_h.bindWe = 1'b0;
    next_h.sampleWe = 1'b0;
    next_h.progLoad = 1'b0;
    next_h.progWe = 1'b0;
    if (h.sampleWe)
    begin
      next_h.sampleAddr = h.sampleAddr + 16'h0001;
    end
    if (h.progWe)
    begin
      next_h.progAddr = h.progAddr + 15'h0001;
    end
    // one wait-free answer: pready in the access cycle
    if (psel && !penable && !h.pready)
    begin
      next_h.pready = 1'b1;
      next_h.pslverr = !mapped;
      next_h.prdata = 32'h0000_0000;
      unique case (paddr)
        pct_pkg::REG_RUN: next_h.prdata = {16'h0000, h.runIndex};
        pct_pkg::REG_CT_ADDR: next_h.prdata = {16'h0000, h.ctAddr};
        pct_pkg::REG_CT_DATA0: next_h.prdata = h.ctWord[0];
        pct_pkg::REG_CT_DATA1: next_h.prdata = h.ctWord[1];
        pct_pkg::REG_CT_DATA2: next_h.prdata = h.ctWord[2];
        pct_pkg::REG_CT_DATA3: next_h.prdata = h.ctWord[3];
        pct_pkg::REG_SAMPLE_ADDR:
          next_h.prdata = {h.sampleAddr, 2'h0, h.sampleWave};
        pct_pkg::REG_PROG_ADDR: next_h.prdata = {17'h00000, h.progAddr};
        pct_pkg::REG_PROG_DATA: next_h.prdata = link.fetchData;
        pct_pkg::REG_STATUS:
          next_h.prdata = {h.playCount, 13'h0000, h.tableLoaded,
            h.bindErr, h.runErr};
        default: next_h.prdata = 32'h0000_0000;
      endcase
    end
    if (wr)
    begin
      unique case (paddr)
        pct_pkg::REG_CTRL:
          if (pwdata[0])
          begin
            next_h.progLoad = 1'b1;
            next_h.tableLoaded = 1'b0;
            next_h.progAddr = '0;
          end
        pct_pkg::REG_RUN:
          if (h.tableLoaded)
          begin
            next_h.runValid = 1'b1;
            next_h.runIndex = pwdata[pct_pkg::CT_IDX_W-1:0];
          end
          else
          begin
            next_h.runErr = 1'b1;
          end
        pct_pkg::REG_CT_ADDR:
          next_h.ctAddr = pwdata[pct_pkg::CT_IDX_W-1:0];
        pct_pkg::REG_CT_DATA0: next_h.ctWord[0] = pwdata;
        pct_pkg::REG_CT_DATA1: next_h.ctWord[1] = pwdata;
        pct_pkg::REG_CT_DATA2: next_h.ctWord[2] = pwdata;
        pct_pkg::REG_CT_DATA3: next_h.ctWord[3] = pwdata;
        pct_pkg::REG_CT_COMMIT:
        begin
          next_h.ctWe = 1'b1;
          next_h.tableLoaded = pwdata[0] | h.tableLoaded;
        end
        pct_pkg::REG_BIND:
        begin
          next_h.bindWave = pwdata[pct_pkg::WAVE_W-1:0];
          next_h.bindDual = pwdata[pct_pkg::BIND_DUAL_BIT];
          next_h.bindLen = pwdata[pct_pkg::LEN_POS +: pct_pkg::LEN_W];
          if (pwdata[pct_pkg::LEN_POS +: pct_pkg::LEN_W]
            < pct_pkg::MIN_WAVE_LEN)
          begin
            next_h.bindErr = 1'b1;
          end
          else
          begin
            next_h.bindWe = 1'b1;
          end
        end
        pct_pkg::REG_SAMPLE_ADDR:
        begin
          next_h.sampleWave = pwdata[pct_pkg::WAVE_W-1:0];
          next_h.sampleAddr = pwdata[pct_pkg::LEN_POS +: pct_pkg::LEN_W];
        end
        pct_pkg::REG_SAMPLE_DATA:
        begin
          next_h.sampleWe = 1'b1;
          next_h.sampleData = pwdata[pct_pkg::VAL_W-1:0];
        end
        pct_pkg::REG_PROG_ADDR:
          next_h.progAddr = pwdata[pct_pkg::PROG_AW-1:0];
        pct_pkg::REG_PROG_DATA:
        begin
          next_h.progWe = 1'b1;
          next_h.progData = pwdata;
        end
        pct_pkg::REG_STATUS:
        begin
          next_h.runErr = h.runErr & ~pwdata[0];
          next_h.bindErr = h.bindErr & ~pwdata[1];
        end
        default: next_h.prdata = h.prdata;
      endcase
    end
    // engine events are set after any clear so they win
    if (link.runError)
    begin
      next_h.runErr = 1'b1;
    end
    if (link.bindError)
    begin
      next_h.bindErr = 1'b1;
    end
    if (link.playStart)
    begin
      next_h.playCount = h.playCount + 16'h0001;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      h <= '0;
    end
    else
    begin
      h <= next_h;
    end
  end

  assign prdata = h.prdata;
  assign pready = h.pready;
  assign pslverr = h.pslverr;
  assign link.runValid = h.runValid;
  assign link.runIndex = h.runIndex;
  assign link.ctWe = h.ctWe;
  assign link.ctAddr = h.ctAddr;
  // entry bits sit in words 0..2 and the low part of word 3
  assign link.ctData = pct_pkg::ct_entry_t'({
    h.ctWord[3][pct_pkg::CT_ENTRY_W-97:0], h.ctWord[2], h.ctWord[1],
    h.ctWord[0]});
  assign link.bindWe = h.bindWe;
  assign link.bindWave = h.bindWave;
  assign link.bindLen = h.bindLen;
  assign link.bindDual = h.bindDual;
  assign link.sampleWe = h.sampleWe;
  assign link.sampleWave = h.sampleWave;
  assign link.sampleAddr = h.sampleAddr;
  assign link.sampleData = h.sampleData;
  assign link.progLoad = h.progLoad;
  assign link.progWe = h.progWe;
  assign link.progAddr = h.progAddr;
  assign link.progData = h.progData;
  assign link.fetchAddr = h.progAddr;
endmodule : table_call_sequencer

// ### sim/pct_checker.sv
`timescale 1ns/1ps
module pct_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // run call
  input wire logic runValid,
  input wire logic [pct_pkg::CT_IDX_W-1:0] runIndex,
  input wire logic playStart,
  input wire logic runError,
  // wave binding
  input wire logic bindWe,
  input wire logic [pct_pkg::WAVE_W-1:0] bindWave,
  input wire logic [pct_pkg::LEN_W-1:0] bindLen,
  input wire logic bindError
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence badCall;
    runValid && runIndex >= pct_pkg::TABLE_DEPTH;
  endsequence

  sequence quietNext;
    !runValid;
  endsequence

  range_error_a: assert property (badCall |=> runError && !playStart)
    else $error("out of range call not refused");
  late_start_a: assert property (badCall ##1 quietNext |=> !playStart)
    else $error("playback after refused call");
  start_cause_a: assert property (playStart |-> $past(runValid)
    && $past(runIndex) < pct_pkg::TABLE_DEPTH)
    else $error("playback without a call one cycle before");
  error_cause_a: assert property (runError |-> $past(runValid))
    else $error("run error without a call");
  start_excl_a: assert property (!(playStart && runError))
    else $error("start and error together");
  bind_accept_a: assert property (bindWe && bindLen >= 16
    && bindWave < pct_pkg::WAVE_DEPTH |=> !bindError)
    else $error("valid binding refused");
  bind_cause_a: assert property (bindError |-> $past(bindWe)
    && ($past(bindLen) < 16 || $past(bindWave) >= pct_pkg::WAVE_DEPTH))
    else $error("binding error without bad binding");
  reset_quiet_a: assert property ($fell(reset) |-> !playStart && !runError)
    else $error("activity right after reset");
endmodule : pct_checker

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic mclk;
  logic reset;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0][15:0] hostGain;
  logic [15:0] hostPhase;
  logic [3:0][31:0] oscFreq;
  logic playStart;
  logic [13:0] direct_wave_play;
  logic [15:0] playLen;
  logic iqMode;
  logic [3:0][15:0] gainOut;
  logic [15:0] phaseOut;
  logic [1:0] oscSel;
  logic sampleWe;
  logic [13:0] sampleWave;
  logic [15:0] sampleAddr;
  logic [15:0] sampleData;
  logic sampleMarker;
  logic [31:0] cap;
  logic [15:0] capAddr;
  int n_fail;
  int n_compared;
  int plays;
  pct_if link ();

  table_call_sequencer i_table_call_sequencer (.mclk(mclk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link));
  pulse_command_table_engine i_pulse_command_table_engine (.mclk(mclk),
    .reset(reset), .link(link), .hostGain(hostGain), .hostPhase(hostPhase),
    .oscFreq(oscFreq), .playStart(playStart), .direct_wave_play(direct_wave_play),
    .playLen(playLen), .iqMode(iqMode), .gainOut(gainOut),
    .phaseOut(phaseOut), .oscSel(oscSel), .sampleWe(sampleWe),
    .sampleWave(sampleWave), .sampleAddr(sampleAddr),
    .sampleData(sampleData), .sampleMarker(sampleMarker));
  pct_checker i_pct_checker (.mclk(mclk), .reset(reset),
    .runValid(link.runValid), .runIndex(link.runIndex),
    .playStart(link.playStart), .runError(link.runError),
    .bindWe(link.bindWe), .bindWave(link.bindWave), .bindLen(link.bindLen),
    .bindError(link.bindError));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // counts playback starts and captures forwarded sample writes
  always @(posedge mclk)
  begin
    if (playStart === 1'b1)
      plays <= plays + 1;
    if (sampleWe === 1'b1)
    begin
      cap <= {sampleMarker, 1'b0, sampleWave, sampleData};
      capAddr <= sampleAddr;
    end
  end

  task automatic wrap_up();
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic xfer(input logic wr, input logic [11:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_fail++;
      wrap_up();
    end
    @(posedge mclk);
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input string what, input logic [11:0] a,
    input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
    check(what, r, exp);
  endtask : rd

  task automatic putEntry(input int idx, input pct_pkg::ct_entry_t e);
    logic [pct_pkg::CT_ENTRY_W-1:0] b;
    b = e;
    wr(pct_pkg::REG_CT_ADDR, 32'(idx));
    wr(pct_pkg::REG_CT_DATA0, b[31:0]);
    wr(pct_pkg::REG_CT_DATA1, b[63:32]);
    wr(pct_pkg::REG_CT_DATA2, b[95:64]);
    wr(pct_pkg::REG_CT_DATA3, 32'(b[pct_pkg::CT_ENTRY_W-1:96]));
    wr(pct_pkg::REG_CT_COMMIT, 32'h1);
  endtask : putEntry

  task automatic run(input int idx);
    wr(pct_pkg::REG_RUN, 32'(idx));
    repeat (4) @(posedge mclk);
  endtask : run

  task automatic chkPlay(input logic [13:0] w, input logic [15:0] len,
    input logic iq, input logic [3:0][15:0] g, input logic [15:0] ph);
    check("wave", 32'(direct_wave_play), 32'(w));
    check("length", 32'(playLen), 32'(len));
    check("iq mode", 32'(iqMode), 32'(iq));
    for (int i = 0; i < 4; i++)
      check("gain", 32'(gainOut[i]), 32'(g[i]));
    check("phase", 32'(phaseOut), 32'(ph));
  endtask : chkPlay

  initial
  begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    wrap_up();
  end

  initial
  begin
    logic [31:0] r;
    logic e;
    pct_pkg::ct_entry_t t;
    logic [15:0] ph0;
    reset <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0;
    hostGain <= {4{16'h0200}};
    hostPhase <= 16'h0000;
    oscFreq <= '0;
    plays = 0;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd("status after reset", pct_pkg::REG_STATUS, 32'h0);
    check("host gain", 32'(gainOut[0]), 32'h0200);
    xfer(1'b0, 12'h038, 32'h0, r, e);
    check("unmapped error", 32'(e), 32'h1);
    check("unmapped data", r, 32'h0);
    wr(pct_pkg::REG_CTRL, 32'h1);
    wr(pct_pkg::REG_PROG_ADDR, 32'h7FFF);
    wr(pct_pkg::REG_PROG_DATA, 32'hA5A50002);
    wr(pct_pkg::REG_PROG_ADDR, 32'h7FFF);
    rd("last program word", pct_pkg::REG_PROG_DATA, 32'hA5A50002);
    wr(pct_pkg::REG_BIND, {16'h0400, 2'b00, 14'h00A});
    wr(pct_pkg::REG_BIND, {16'h0010, 2'b01, 14'h00B});
    rd("bind ok", pct_pkg::REG_STATUS, 32'h0);
    wr(pct_pkg::REG_BIND, {16'h000F, 2'b00, 14'h00C});
    rd("short bind", pct_pkg::REG_STATUS, 32'h2);
    wr(pct_pkg::REG_STATUS, 32'h3);
    wr(pct_pkg::REG_BIND, {16'h0010, 2'b00, 14'h3FFF});
    @(posedge mclk);
    rd("wave slot range", pct_pkg::REG_STATUS, 32'h2);
    wr(pct_pkg::REG_STATUS, 32'h2);
    wr(pct_pkg::REG_SAMPLE_ADDR, {16'h0005, 2'b00, 14'h00A});
    wr(pct_pkg::REG_SAMPLE_DATA, 32'h00001235);
    repeat (2) @(posedge mclk);
    check("sample one", cap, 32'h800A1235);
    check("sample one addr", 32'(capAddr), 32'h5);
    wr(pct_pkg::REG_SAMPLE_DATA, 32'h00004442);
    repeat (2) @(posedge mclk);
    check("sample two", cap, 32'h000A4442);
    check("sample two addr", 32'(capAddr), 32'h6);
    t = '0;
    t.waveEn = 1'b1;
    t.wave = 14'h00A;
    t.phaseEn = 1'b1;
    t.phase = 16'h4000;
    t.gainEn = 4'hF;
    t.gain = {16'h1000, 16'h1000, 16'hF000, 16'h1000};
    t.oscEn = 1'b1;
    t.osc = 2'h1;
    putEntry(0, t);
    t = '0;
    t.waveEn = 1'b1;
    t.wave = 14'h00B;
    t.phaseEn = 1'b1;
    t.phaseInc = 1'b1;
    t.phase = 16'h0100;
    t.gainEn = 4'h3;
    t.gainInc = 4'h3;
    t.gain = {16'h0000, 16'h0000, 16'hFF00, 16'h0100};
    putEntry(1, t);
    t = '0;
    t.gainEn = 4'h4;
    t.gain = {16'h0000, 16'h2222, 16'h0000, 16'h0000};
    putEntry(2, t);
    rd("table loaded", pct_pkg::REG_STATUS, 32'h4);
    run(0);
    chkPlay(14'h00A, 16'h0400, 1'b0, {16'h1000, 16'h1000, 16'hF000,
      16'h1000}, 16'h4000);
    check("oscillator", 32'(oscSel), 32'h1);
    hostGain <= {4{16'h7777}};
    repeat (2) @(posedge mclk);
    check("table gain wins", 32'(gainOut[0]), 32'h1000);
    repeat (3) run(1);
    chkPlay(14'h00B, 16'h0010, 1'b1, {16'h1000, 16'h1000, 16'hED00,
      16'h1300}, 16'h4300);
    run(2);
    check("no play count", 32'(plays), 32'h4);
    check("absolute c", 32'(gainOut[2]), 32'h2222);
    rd("play count", pct_pkg::REG_STATUS, 32'h00040004);
    run(4096);
    rd("range refused", pct_pkg::REG_STATUS, 32'h00040005);
    wr(pct_pkg::REG_STATUS, 32'h1);
    run(3);
    rd("undefined refused", pct_pkg::REG_STATUS, 32'h00040005);
    wr(pct_pkg::REG_STATUS, 32'h1);
    wr(pct_pkg::REG_CTRL, 32'h1);
    run(0);
    rd("cleared table", pct_pkg::REG_STATUS, 32'h00040001);
    check("no play after load", 32'(plays), 32'h4);
    wr(pct_pkg::REG_STATUS, 32'h1);
    wr(pct_pkg::REG_CT_COMMIT, 32'h1);
    run(0);
    rd("engine table cleared", pct_pkg::REG_STATUS, 32'h00040005);
    oscFreq <= {4{32'h0001_0000}};
    repeat (2) @(posedge mclk);
    ph0 = phaseOut;
    repeat (8) @(posedge mclk);
    check("oscillator advance", 32'(phaseOut), 32'(ph0 + 16'h0008));
    wrap_up();
  end
endmodule : tb
